// [rtl/mss_pkg.sv]
// package: constants, types and shared functions of the modem status scanner
package mss_pkg;

  // line count and scan clock derivation
  localparam int         NUM_LINES      = 16;
  localparam int         CLK_PERIOD_NS  = 20;
  localparam int         SCAN_PERIOD_NS = 1000;
  localparam int         SCAN_TICK_CYC  = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] SCAN_TICK_LAST = 6'(SCAN_TICK_CYC - 1);

  // register byte offsets on the slave bus
  localparam logic [3:0] OFS_CSR  = 4'h0;
  localparam logic [3:0] OFS_LINE = 4'h4;

  // control and status register fields
  localparam int CSR_LINE_LSB = 0;
  localparam int CSR_BUSY     = 4;
  localparam int CSR_SCAN_EN  = 5;
  localparam int CSR_STEP     = 6;
  localparam int CSR_DONE     = 7;
  localparam int CSR_IRQ_EN   = 8;
  localparam int CSR_LOOP     = 9;
  localparam int CSR_WIPE     = 10;
  localparam int CSR_CLEAR    = 11;

  // line register fields: outgoing controls low, incoming statuses above
  localparam int LR_CTRL_LSB = 0;
  localparam int LR_STAT_LSB = 4;

  // index of each status within a four-bit status word
  localparam int STAT_SRX  = 0;
  localparam int STAT_CTS  = 1;
  localparam int STAT_CAR  = 2;
  localparam int STAT_RING = 3;

  // reset values
  localparam logic [3:0] RST_LINE = 4'h0;
  localparam logic [5:0] RST_DIV  = 6'h00;
  localparam logic [2:0] BR_LEVEL = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADVANCE,
    ST_LOAD,
    ST_STORE,
    ST_TEST
  } mss_state_t;

  // change test: three statuses either way, ring only on a rise
  function automatic logic mss_change(logic [3:0] prev, logic [3:0] cur);
    return (|((prev ^ cur) & 4'h7)) | (cur[STAT_RING] & ~prev[STAT_RING]);
  endfunction

endpackage

// [rtl/mss_scan_mem.sv]
// scan memory: last stored status of each line
`timescale 1ns/10ps
module mss_scan_mem
  import mss_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // write and read port
  input  wire logic       we,
  input  wire logic [3:0] addr,
  input  wire logic [3:0] wd,
  output logic      [3:0] rd
);

  typedef struct packed {
    logic [NUM_LINES-1:0][3:0] mem;
  } mss_mem_t;

  mss_mem_t s_r;
  mss_mem_t s_nxt;

  // read is combinational so the load step sees the word at once
  assign rd = s_r.mem[addr];

  always_comb begin
    s_nxt = s_r;
    if (we) begin
      s_nxt.mem[addr] = wd;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  AST_MEM_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    we |=> s_r.mem[$past(addr)] == $past(wd))
    else $error("scan memory did not store the written status");

endmodule

// [rtl/mss_line_ctrl.sv]
// per-line outgoing modem controls, written one line at a time
`timescale 1ns/10ps
module mss_line_ctrl
  import mss_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // per-line write port
  input  wire logic [3:0]  line,
  input  wire logic        wr,
  input  wire logic [3:0]  wd,
  // modem-facing controls
  output logic      [15:0] line_enable,
  output logic      [15:0] secondary_transmit,
  output logic      [15:0] terminal_ready,
  output logic      [15:0] send_request,
  // controls of the selected line
  output logic      [3:0]  sel_ctrl
);

  typedef struct packed {
    logic [15:0] en;
    logic [15:0] stx;
    logic [15:0] trdy;
    logic [15:0] rts;
  } mss_lc_t;

  mss_lc_t     s_r;
  mss_lc_t     s_nxt;
  logic [15:0] strobe;

  // one-hot strobe within an eight-line group, empty if the group is not selected
  function automatic logic [7:0] grp_decode(logic [3:0] l, logic g);
    return (l[3] == g) ? (8'h01 << l[2:0]) : 8'h00;
  endfunction

  assign strobe             = {grp_decode(line, 1'b1), grp_decode(line, 1'b0)};
  assign line_enable        = s_r.en;
  assign secondary_transmit = s_r.stx;
  assign terminal_ready     = s_r.trdy;
  assign send_request       = s_r.rts;
  assign sel_ctrl           = {s_r.rts[line], s_r.trdy[line], s_r.stx[line], s_r.en[line]};

  // only the strobed line takes the data bits
  always_comb begin
    s_nxt = s_r;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (wr && strobe[i]) begin
        s_nxt.en[i]   = wd[0];
        s_nxt.stx[i]  = wd[1];
        s_nxt.trdy[i] = wd[2];
        s_nxt.rts[i]  = wd[3];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  AST_LC_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    wr |=> (sel_ctrl == $past(wd)) || (line != $past(line)))
    else $error("line controls did not take the written bits");

endmodule

// [rtl/mss_scanner.sv]
// top of the modem status scanner: bus slave, scan sequencer and change test
//
// How it works
// - scan clear or bus init clears control and counters, starts memory wipe
// - during wipe the previous latches stay zero and inputs are kept out of memory
// - wipe ends at the store step of line zero, all lines then hold zeros
// - scan runs while scan enable is set and done is clear
// - each line runs advance, load previous, store, check change in order
// - single step runs one advance, clears itself, finishes the line, rests
// - software loads the line counter from data bits 3 to 0
// - store step writes the line's four incoming statuses into memory
// - load step copies the line's stored status into the previous latches
// - three statuses flag either edge; ring flags only a rise
// - check step sets done on a change if the line is enabled
// - interrupt request while done and interrupt enable are both set
// - a change after a counter reload, before a load step, is ignored
// - outgoing controls read and write, incoming statuses read only
// - incoming statuses read as zero unless the line is enabled
// - line register write puts data bits 3 to 0 on the line's controls
// - per-line writes go to group 0-7 or 8-15 by the counter
// - incoming selectors open only with wipe clear and the line enabled; the line register readback selector ignores wipe
// - loopback test forces the selected line's incoming statuses low
// - interrupt is requested at bus request level 4
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module mss_scanner
  import mss_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        bus_init,
  // register bus slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // incoming modem statuses, one bit per line
  input  wire logic [15:0] secondary_receive,
  input  wire logic [15:0] clear_to_send,
  input  wire logic [15:0] carrier,
  input  wire logic [15:0] ring,
  // outgoing modem controls
  output logic      [15:0] line_enable,
  output logic      [15:0] secondary_transmit,
  output logic      [15:0] terminal_ready,
  output logic      [15:0] send_request,
  // interrupt request
  output logic             irq,
  output logic      [2:0]  bus_request_level
);

  typedef struct packed {
    logic [NUM_LINES-1:0][3:0] sync1;
    logic [NUM_LINES-1:0][3:0] sync2;
    logic                      wait_r;
    logic [31:0]               rdata;
    logic [5:0]                div;
    mss_state_t                state;
    logic [3:0]                line;
    logic                      scan_en;
    logic                      step;
    logic                      done;
    logic                      irq_en;
    logic                      loop;
    logic                      wipe;
    logic                      invalid;
    logic [3:0]                hold;
    logic                      irq;
    logic [2:0]                br;
  } mss_regs_t;

  mss_regs_t   s_r;
  mss_regs_t   s_nxt;

  logic        req_c;
  logic        acc_c;
  logic        csr_hit;
  logic        line_hit;
  logic        tick_c;
  logic        active_c;
  logic        rse_c;
  logic [3:0]  cur_c;
  logic [3:0]  shown_c;
  logic        change_c;
  logic        clear_c;
  logic        done_set;
  logic        mem_we_c;
  logic        lc_wr_c;
  logic [3:0]  mem_rd;
  logic [3:0]  lc_sel;
  logic [31:0] csr_c;
  logic [31:0] line_c;

  // scan memory and per-line controls
  mss_scan_mem u_mem (
    .sys_clk (sys_clk),
    .rst     (rst),
    .we      (mem_we_c),
    .addr    (s_r.line),
    .wd      (cur_c),
    .rd      (mem_rd)
  );

  mss_line_ctrl u_lc (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .line               (s_r.line),
    .wr                 (lc_wr_c),
    .wd                 (avs_writedata[3:0]),
    .line_enable        (line_enable),
    .secondary_transmit (secondary_transmit),
    .terminal_ready     (terminal_ready),
    .send_request       (send_request),
    .sel_ctrl           (lc_sel)
  );

  // bus decode; a request is accepted on the edge where waitrequest is low
  assign req_c    = avs_read | avs_write;
  assign acc_c    = req_c & ~s_r.wait_r;
  assign csr_hit  = (avs_address == OFS_CSR);
  assign line_hit = (avs_address == OFS_LINE);
  assign tick_c   = (s_r.div == SCAN_TICK_LAST);

  // incoming status path of the selected line
  assign active_c = lc_sel[0];
  assign rse_c    = ~s_r.wipe & active_c;
  assign cur_c    = (rse_c & ~s_r.loop) ? s_r.sync2[s_r.line] : 4'h0;
  assign shown_c  = (active_c & ~s_r.loop) ? s_r.sync2[s_r.line] : 4'h0;
  assign change_c = mss_change(s_r.hold, mem_rd);

  // scan clear from software, or bus init, restarts the scan; the per-line controls are kept
  assign clear_c = bus_init
                 | (acc_c & avs_write & csr_hit & avs_byteenable[1] & avs_writedata[CSR_CLEAR]);
  assign lc_wr_c = acc_c & avs_write & line_hit & avs_byteenable[0];

  // readback images; unused bits read as zero
  always_comb begin
    csr_c                              = '0;
    csr_c[CSR_LINE_LSB +: 4]           = s_r.line;
    csr_c[CSR_BUSY]                    = (s_r.state != ST_IDLE);
    csr_c[CSR_SCAN_EN]                 = s_r.scan_en;
    csr_c[CSR_STEP]                    = s_r.step;
    csr_c[CSR_DONE]                    = s_r.done;
    csr_c[CSR_IRQ_EN]                  = s_r.irq_en;
    csr_c[CSR_LOOP]                    = s_r.loop;
    csr_c[CSR_WIPE]                    = s_r.wipe;
    line_c                             = '0;
    line_c[LR_CTRL_LSB +: 4]           = lc_sel;
    line_c[LR_STAT_LSB +: 4]           = shown_c;
  end

  // next state of every register
  always_comb begin
    s_nxt    = s_r;
    done_set = 1'b0;
    mem_we_c = 1'b0;

    // two flops on every modem input; only sync2 is read
    for (int i = 0; i < NUM_LINES; i++) begin
      s_nxt.sync1[i] = {ring[i], carrier[i], clear_to_send[i], secondary_receive[i]};
    end
    s_nxt.sync2 = s_r.sync1;

    // one wait cycle, then one ready cycle per request
    s_nxt.wait_r = ~(req_c & s_r.wait_r);
    if (req_c & s_r.wait_r & avs_read) begin
      s_nxt.rdata = csr_hit ? csr_c : (line_hit ? line_c : 32'h0000_0000);
    end

    // scan clock divider, one tick per microsecond
    s_nxt.div = tick_c ? RST_DIV : 6'(s_r.div + 6'h01);

    // four-step sequencer, one step per scan tick
    if (tick_c) begin
      case (s_r.state)
        ST_IDLE: begin
          if (s_r.wipe || (s_r.scan_en && !s_r.done) || s_r.step) begin
            s_nxt.state = ST_ADVANCE;
          end
        end
        ST_ADVANCE: begin
          s_nxt.line  = 4'(s_r.line + 4'h1);
          s_nxt.step  = 1'b0;
          s_nxt.state = ST_LOAD;
        end
        ST_LOAD: begin
          s_nxt.hold    = mem_rd;
          s_nxt.invalid = 1'b0;
          s_nxt.state   = ST_STORE;
        end
        ST_STORE: begin
          mem_we_c = 1'b1;
          if (s_r.wipe && (s_r.line == 4'h0)) begin
            s_nxt.wipe = 1'b0;
          end
          s_nxt.state = ST_TEST;
        end
        ST_TEST: begin
          if (change_c && active_c && !s_r.invalid && !s_r.wipe) begin
            done_set = 1'b1;
          end
          // free run goes straight on; a step or a hit comes to rest
          if (s_r.wipe || (s_r.scan_en && !s_r.done && !done_set)) begin
            s_nxt.state = ST_ADVANCE;
          end else begin
            s_nxt.state = ST_IDLE;
          end
        end
        default: begin
          s_nxt.state = ST_IDLE;
        end
      endcase
    end

    // software writes to the control register
    if (acc_c && avs_write && csr_hit) begin
      if (avs_byteenable[0]) begin
        s_nxt.line    = avs_writedata[CSR_LINE_LSB +: 4];
        s_nxt.invalid = 1'b1;
        s_nxt.scan_en = avs_writedata[CSR_SCAN_EN];
        s_nxt.step    = avs_writedata[CSR_STEP];
        if (!avs_writedata[CSR_DONE]) begin
          s_nxt.done = 1'b0;
        end
      end
      if (avs_byteenable[1]) begin
        s_nxt.irq_en = avs_writedata[CSR_IRQ_EN];
        s_nxt.loop   = avs_writedata[CSR_LOOP];
      end
    end

    // a hit in the same cycle as a software clear is kept
    if (done_set) begin
      s_nxt.done = 1'b1;
    end

    // clear beats everything, including the hit above
    if (clear_c) begin
      s_nxt.state   = ST_IDLE;
      s_nxt.line    = RST_LINE;
      s_nxt.div     = RST_DIV;
      s_nxt.scan_en = 1'b0;
      s_nxt.step    = 1'b0;
      s_nxt.done    = 1'b0;
      s_nxt.irq_en  = 1'b0;
      s_nxt.loop    = 1'b0;
      s_nxt.invalid = 1'b0;
      s_nxt.wipe    = 1'b1;
    end

    // previous latches are held at zero for the whole wipe
    if (s_nxt.wipe) begin
      s_nxt.hold = 4'h0;
    end

    s_nxt.irq = s_nxt.done & s_nxt.irq_en;
    s_nxt.br  = BR_LEVEL;
  end

  // reset starts a wipe just like a scan clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r        <= '0;
      s_r.wait_r <= 1'b1;
      s_r.wipe   <= 1'b1;
      s_r.br     <= BR_LEVEL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata      = s_r.rdata;
  assign avs_waitrequest   = s_r.wait_r;
  assign irq               = s_r.irq;
  assign bus_request_level = s_r.br;

  // checks on the sequencer and the bus
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_step(mss_state_t st);
    (s_r.state == st) && tick_c && !clear_c;
  endsequence

  sequence seq_csr_write;
    acc_c && avs_write && csr_hit && avs_byteenable[0] && !clear_c;
  endsequence

  AST_CLEAR: assert property (clear_c |=> s_r.wipe && (s_r.line == RST_LINE) && !s_r.done
                              && (s_r.state == ST_IDLE))
    else $error("clear did not reset the scan and start a wipe");

  AST_WIPE_HOLD: assert property (s_r.wipe |-> (s_r.hold == 4'h0) && (cur_c == 4'h0))
    else $error("previous latches or inputs open during wipe");

  AST_WIPE_END: assert property (seq_step(ST_STORE) ##0 (s_r.wipe && s_r.line == 4'h0)
                                 |=> !s_r.wipe)
    else $error("wipe did not end at line zero store");

  AST_STOP_ON_DONE: assert property ((s_r.state == ST_IDLE) && s_r.done && !s_r.step && !s_r.wipe
                                     && !acc_c && !bus_init |=> (s_r.state == ST_IDLE))
    else $error("sequencer advanced with done set");

  // the load step comes one tick after the advance; a clear in between ends the attempt
  AST_ORDER: assert property (disable iff (rst || clear_c) seq_step(ST_ADVANCE)
                              |=> (s_r.state == ST_LOAD) ##49 seq_step(ST_LOAD) ##1 (s_r.state == ST_STORE))
    else $error("sequencer steps out of order");

  AST_ADVANCE: assert property (seq_step(ST_ADVANCE) ##0 !acc_c
                                |=> s_r.line == 4'($past(s_r.line) + 4'h1))
    else $error("line counter did not advance by one");

  AST_STEP_CLEAR: assert property (seq_step(ST_ADVANCE) ##0 !acc_c |=> !s_r.step)
    else $error("single step not cleared by the advance");

  AST_LINE_LOAD: assert property (seq_csr_write |=> (s_r.line == $past(avs_writedata[3:0]))
                                  && s_r.invalid)
    else $error("line counter not loaded from the bus");

  AST_HOLD_LOAD: assert property (seq_step(ST_LOAD) ##0 !s_r.wipe |=> s_r.hold == $past(mem_rd))
    else $error("previous latches not loaded from memory");

  AST_DONE_SET: assert property (seq_step(ST_TEST) ##0 (change_c && active_c && !s_r.invalid
                                 && !s_r.wipe) |=> s_r.done)
    else $error("detected change did not set done");

  AST_NO_INVALID: assert property (seq_step(ST_TEST) ##0 (s_r.invalid && !s_r.done)
                                   ##1 !(acc_c && avs_write) |-> !s_r.done)
    else $error("stale comparison raised done");

  AST_IRQ: assert property ((s_r.done && s_r.irq_en) ##1 (s_r.done && s_r.irq_en) |-> irq
                            && (bus_request_level == BR_LEVEL))
    else $error("interrupt request missing or at wrong level");

  AST_READ_BLIND: assert property (req_c && s_r.wait_r && avs_read && line_hit && !active_c
                                   |=> avs_readdata[LR_STAT_LSB +: 4] == 4'h0)
    else $error("incoming status visible on a disabled line");

  AST_BUS_ANSWER: assert property (req_c && s_r.wait_r |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

endmodule

// [bench/mss_modem_model.sv]
// partner model: sixteen modems whose status lines are set one line at a time
`timescale 1ns/10ps
module mss_modem_model
  import mss_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // new status word for one line
  input  wire logic        set_stb,
  input  wire logic [3:0]  set_line,
  input  wire logic [3:0]  set_val,
  // status levels toward the scanner
  output logic      [15:0] secondary_receive,
  output logic      [15:0] clear_to_send,
  output logic      [15:0] carrier,
  output logic      [15:0] ring
);
  typedef struct packed {
    logic [15:0] srx;
    logic [15:0] cts;
    logic [15:0] car;
    logic [15:0] rng;
  } mss_modem_t;
  mss_modem_t st_r;
  mss_modem_t st_nxt;
  // levels are held between updates, as a real modem holds its leads
  always_comb begin
    st_nxt = st_r;
    if (set_stb) begin
      st_nxt.srx[set_line] = set_val[STAT_SRX];
      st_nxt.cts[set_line] = set_val[STAT_CTS];
      st_nxt.car[set_line] = set_val[STAT_CAR];
      st_nxt.rng[set_line] = set_val[STAT_RING];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign secondary_receive = st_r.srx;
  assign clear_to_send     = st_r.cts;
  assign carrier           = st_r.car;
  assign ring              = st_r.rng;
endmodule

// [bench/mss_scanner_test.sv]
// self-checking testbench of the modem status scanner
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module mss_scanner_test
  import mss_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic        bus_init;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] secondary_receive;
  logic [15:0] clear_to_send;
  logic [15:0] carrier;
  logic [15:0] ring;
  logic [15:0] line_enable;
  logic [15:0] secondary_transmit;
  logic [15:0] terminal_ready;
  logic [15:0] send_request;
  logic        irq;
  logic [2:0]  bus_request_level;
  logic        set_stb;
  logic [3:0]  set_line;
  logic [3:0]  set_val;
  logic [31:0] q;
  int          n_errors;
  int          checks;
  localparam logic [31:0] B_STEP = 32'h1 << CSR_STEP;
  localparam logic [31:0] B_SCAN = 32'h1 << CSR_SCAN_EN;
  localparam logic [31:0] B_IRQ  = 32'h1 << CSR_IRQ_EN;
  localparam logic [31:0] B_LOOP = 32'h1 << CSR_LOOP;

  mss_scanner i_dut (.sys_clk(sys_clk), .rst(rst), .bus_init(bus_init), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h3),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .secondary_receive(secondary_receive),
    .clear_to_send(clear_to_send), .carrier(carrier), .ring(ring), .line_enable(line_enable),
    .secondary_transmit(secondary_transmit), .terminal_ready(terminal_ready), .send_request(send_request),
    .irq(irq), .bus_request_level(bus_request_level));
  mss_modem_model i_modem (.sys_clk(sys_clk), .rst(rst), .set_stb(set_stb), .set_line(set_line),
    .set_val(set_val), .secondary_receive(secondary_receive), .clear_to_send(clear_to_send),
    .carrier(carrier), .ring(ring));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one bus cycle; the request is held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rq);
    int i;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i == 50) begin
      n_errors++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] rq);
    bus(1'b0, a, 32'h0, rq);
  endtask

  // poll a csr bit under a bound; a wipe takes about 3200 cycles
  task automatic wait_bit(input int b, input logic v);
    int j;
    for (j = 0; j < 2000; j++) begin
      rd(OFS_CSR, q);
      if (q[b] === v) break;
    end
    if (j == 2000) begin
      n_errors++;
      finish_test();
    end
  endtask

  task automatic modem_set(input logic [3:0] ln, input logic [3:0] v);
    @(posedge sys_clk);
    set_stb  <= 1'b1;
    set_line <= ln;
    set_val  <= v;
    @(posedge sys_clk);
    set_stb <= 1'b0;
  endtask

  // single step from line 2 onto line 3, then check the done flag
  task automatic step_line(input logic [31:0] extra, input logic exp_done);
    wr(OFS_CSR, 32'h2 | B_STEP | extra);
    wait_bit(CSR_STEP, 1'b0);
    wait_bit(CSR_BUSY, 1'b0);
    `CHK("line after step", 4'h3, q[3:0])
    `CHK("done after step", exp_done, q[CSR_DONE])
  endtask

  // hang guard, well above the longest sequence
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    bus_init = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    set_stb = 1'b0;
    set_line = 4'h0;
    set_val = 4'h0;
    n_errors = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    // reset: wipe runs, then the counter rests at zero
    rd(OFS_CSR, q);
    `CHK("wipe after reset", 1'b1, q[CSR_WIPE])
    `CHK("bus level", BR_LEVEL, bus_request_level)
    wait_bit(CSR_WIPE, 1'b0);
    `CHK("line after wipe", 4'h0, q[3:0])
    `CHK("irq idle", 1'b0, irq)
    $display("test reset done");
    // line controls and readable statuses
    wr(OFS_CSR, 32'h3);
    modem_set(4'h3, 4'hc);
    wr(OFS_LINE, 32'hff);
    rd(OFS_LINE, q);
    `CHK("line 3 register", 8'hcf, q[7:0])
    `CHK("line 3 outputs", 4'hf, {send_request[3], terminal_ready[3], secondary_transmit[3], line_enable[3]})
    wr(OFS_CSR, 32'hb);
    wr(OFS_LINE, 32'h1);
    @(posedge sys_clk);
    `CHK("enables", 16'h0808, line_enable)
    modem_set(4'h5, 4'hf);
    wr(OFS_CSR, 32'h5);
    rd(OFS_LINE, q);
    `CHK("disabled line", 8'h00, q[7:0])
    rd(4'h8, q);
    `CHK("unmapped read", 32'h0, q)
    $display("test line register done");
    // single step against wiped memory flags the set statuses
    step_line(32'h0, 1'b1);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_CSR, 32'h3 | B_IRQ | (32'h1 << CSR_DONE));
    rd(OFS_CSR, q);
    `CHK("irq raised", 1'b1, irq)
    wr(OFS_CSR, 32'h3);
    rd(OFS_CSR, q);
    `CHK("done cleared", 1'b0, q[CSR_DONE])
    `CHK("irq dropped", 1'b0, irq)
    // ring falling is ignored, carrier falling is flagged
    modem_set(4'h3, 4'h4);
    step_line(32'h0, 1'b0);
    modem_set(4'h3, 4'h0);
    step_line(32'h0, 1'b1);
    wr(OFS_CSR, 32'h3);
    $display("test single step done");
    // free scan from line 3 wraps through fifteen back to line 3
    modem_set(4'h3, 4'h2);
    wr(OFS_CSR, 32'h3 | B_SCAN | B_IRQ);
    wait_bit(CSR_DONE, 1'b1);
    `CHK("line at done", 4'h3, q[3:0])
    repeat (300) @(posedge sys_clk);
    rd(OFS_CSR, q);
    `CHK("line held", 4'h3, q[3:0])
    `CHK("irq on scan", 1'b1, irq)
    wr(OFS_CSR, 32'h3);
    $display("test free scan done");
    // loopback forces the selected statuses low and makes a change
    wr(OFS_CSR, 32'h3 | B_LOOP);
    rd(OFS_LINE, q);
    `CHK("loopback read", 8'h0f, q[7:0])
    step_line(B_LOOP, 1'b1);
    $display("test loopback done");
    // a counter write between load and check makes the cts rise on line 3 stale
    wr(OFS_CSR, 32'h3);
    wr(OFS_CSR, 32'h2 | B_STEP);
    wait_bit(CSR_STEP, 1'b0);
    repeat (60) @(posedge sys_clk);
    wr(OFS_CSR, 32'h3);
    wait_bit(CSR_BUSY, 1'b0);
    `CHK("stale change", 1'b0, q[CSR_DONE])
    `CHK("line after stale", 4'h3, q[3:0])
    $display("test stale compare done");
    // scan clear and bus init restart the wipe, line controls stay
    wr(OFS_CSR, 32'h1 << CSR_CLEAR);
    rd(OFS_CSR, q);
    `CHK("wipe on clear", 1'b1, q[CSR_WIPE])
    `CHK("done on clear", 1'b0, q[CSR_DONE])
    `CHK("controls kept", 16'h0808, line_enable)
    wait_bit(CSR_WIPE, 1'b0);
    `CHK("line after clear", 4'h0, q[3:0])
    @(posedge sys_clk);
    bus_init <= 1'b1;
    @(posedge sys_clk);
    bus_init <= 1'b0;
    rd(OFS_CSR, q);
    `CHK("wipe on init", 1'b1, q[CSR_WIPE])
    wait_bit(CSR_WIPE, 1'b0);
    $display("test scan clear done");
    finish_test();
  end
endmodule
